// >>> shared/omf_cfg.svh
`ifndef OMF_CFG_SVH
`define OMF_CFG_SVH

// Register byte offsets
`define OMF_OFS_POINTS   8'h00
`define OMF_OFS_KIND     8'h04
`define OMF_OFS_PATTERN  8'h08
`define OMF_OFS_DELAY    8'h0C
`define OMF_OFS_COMMIT   8'h10
`define OMF_OFS_STATUS   8'h14
`define OMF_OFS_IRQSTAT  8'h18
`define OMF_OFS_IRQMASK  8'h1C
`define OMF_OFS_WATCH    8'h20

// Field positions
`define OMF_BIT_COMMIT   0
`define OMF_BIT_SAFE     0
`define OMF_BIT_LOSS     1
`define OMF_IRQ_ENTER    0
`define OMF_IRQ_LEAVE    1
`define OMF_IRQ_COMMIT   2

// Reset values
`define OMF_RST_POINTS   8'h00
`define OMF_RST_KIND     8'h01
`define OMF_RST_PATTERN  8'h00
`define OMF_RST_DELAY    8'h00
`define OMF_RST_WATCH    16'h03E8

// Timing: one delay unit is a tenth of a second
`define OMF_CLOCK_HZ     100000000
`define OMF_TICK_MS      100
`define OMF_TICK_CYCLES  ((`OMF_CLOCK_HZ / 1000) * `OMF_TICK_MS)

`endif

// >>> shared/omf_pkg.sv
package omf_pkg;
    typedef enum logic [1:0] {
        OMF_KIND_NONE,
        OMF_KIND_OFF,
        OMF_KIND_PATTERN,
        OMF_KIND_HOLD
    } omf_kind_e;

    typedef enum logic [1:0] {
        OMF_RUN,
        OMF_WAIT,
        OMF_SAFE
    } omf_state_e;
endpackage : omf_pkg

// >>> rtl/omf_tick_div.sv
`timescale 1ns/1ns
`include "omf_cfg.svh"

// Divider giving a one-cycle pulse per tenth of a second
module omf_tick_div #(
    parameter int TICK_CYCLES = `OMF_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // Restart and pulse
    input  wire logic restart,
    output logic      tick
);
    logic [31:0] count;
    wire         atEnd = (count == 32'(TICK_CYCLES - 1));

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            count <= 32'h00000000;
            tick  <= 1'b0;
        end else begin
            tick  <= atEnd & ~restart;
            count <= (restart | atEnd) ? 32'h00000000 : count + 32'h00000001;
        end
    end
endmodule : omf_tick_div

// >>> rtl/omf_output_failsafe.sv
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "omf_cfg.svh"

module omf_output_failsafe #(
    parameter int POINTS      = 8,
    parameter int TICK_CYCLES = `OMF_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                reset,
    // Host link activity
    input  wire logic                hostAlive,
    // AXI4-Lite write address
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [7:0]          s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    // AXI4-Lite write response
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    output logic [1:0]               s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    input  wire logic [7:0]          s_axi_araddr,
    // AXI4-Lite read data
    input  wire logic                s_axi_rready,
    output logic                     s_axi_rvalid,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    // Outputs
    output logic [POINTS-1:0]        points,
    output logic                     inSafe,
    output logic                     irq
);
    // Staged and live configuration
    logic [POINTS-1:0]       userPoints;
    logic [7:0]              stageKind;
    logic [POINTS-1:0]       stagePattern;
    logic [7:0]              stageDelay;
    logic [7:0]              liveKind;
    logic [POINTS-1:0]       livePattern;
    logic [7:0]              liveDelay;
    logic                    commitFlag;
    logic [15:0]             watchLimit;
    logic [15:0]             watchCount;
    logic [7:0]              delayCount;
    logic [2:0]              irqStat;
    logic [2:0]              irqMask;
    logic [POINTS-1:0]       heldPoints;
    omf_pkg::omf_state_e     state;
    omf_pkg::omf_state_e     next_state;

    // Write channel capture
    logic                    awHeld;
    logic                    wHeld;
    logic [7:0]              awAddr;
    logic [31:0]             wData;
    logic [3:0]              wStrb;

    wire awTake  = s_axi_awvalid & s_axi_awready;
    wire wTake   = s_axi_wvalid & s_axi_wready;
    wire doWrite = awHeld & wHeld & ~s_axi_bvalid;
    wire lane0   = wStrb[0];
    wire wrPts   = doWrite & lane0 & (awAddr == `OMF_OFS_POINTS);
    wire wrKind  = doWrite & lane0 & (awAddr == `OMF_OFS_KIND);
    wire wrPat   = doWrite & lane0 & (awAddr == `OMF_OFS_PATTERN);
    wire wrDly   = doWrite & lane0 & (awAddr == `OMF_OFS_DELAY);
    wire wrCom   = doWrite & lane0 & (awAddr == `OMF_OFS_COMMIT);
    wire wrIst   = doWrite & lane0 & (awAddr == `OMF_OFS_IRQSTAT);
    wire wrMsk   = doWrite & lane0 & (awAddr == `OMF_OFS_IRQMASK);
    wire wrWatch = doWrite & (awAddr == `OMF_OFS_WATCH);
    // Upper lane comes from the captured strobes; the bus may have moved on
    wire wrKnown = wrPts | wrKind | wrPat | wrDly | wrCom | wrIst | wrMsk | wrWatch
                   | (doWrite & ~lane0 & (awAddr <= `OMF_OFS_WATCH) & (awAddr[1:0] == 2'b00));

    // Commit: writing zero is no action, a one is applied next cycle
    wire commitSet = wrCom & wData[`OMF_BIT_COMMIT];
    wire applyCfg  = commitFlag;

    // Host activity watchdog; a write from software also counts as host traffic
    wire hostSeen  = hostAlive | doWrite;
    wire linkLost  = (watchCount >= watchLimit);
    wire tick;

    omf_tick_div #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clock  (clock),
        .reset  (reset),
        .restart(hostSeen),
        .tick   (tick)
    );

    // Safe-state sequencing
    wire delayDone = (delayCount >= liveDelay);
    always_comb begin
        next_state = state;
        case (state)
            omf_pkg::OMF_RUN:  if (linkLost) next_state = omf_pkg::OMF_WAIT;
            omf_pkg::OMF_WAIT: begin
                if (hostSeen)       next_state = omf_pkg::OMF_RUN;
                else if (delayDone) next_state = omf_pkg::OMF_SAFE;
            end
            omf_pkg::OMF_SAFE: if (hostSeen) next_state = omf_pkg::OMF_RUN;
            default:           next_state = omf_pkg::OMF_RUN;
        endcase
    end

    // Safe output pattern decode
    wire kindOff  = (liveKind == 8'(omf_pkg::OMF_KIND_OFF));
    wire kindPat  = (liveKind == 8'(omf_pkg::OMF_KIND_PATTERN));
    wire kindHold = (liveKind == 8'(omf_pkg::OMF_KIND_HOLD));
    wire enterSafe = (next_state == omf_pkg::OMF_SAFE) & (state != omf_pkg::OMF_SAFE);
    wire leaveSafe = (state == omf_pkg::OMF_SAFE) & (next_state != omf_pkg::OMF_SAFE);
    logic [POINTS-1:0] safePoints;
    genvar gi;
    generate
        for (gi = 0; gi < POINTS; gi++) begin : g_point
            assign safePoints[gi] = kindPat  ? livePattern[gi] :
                                    kindHold ? heldPoints[gi]  :
                                    kindOff  ? 1'b0 : heldPoints[gi];
        end
    endgenerate
    wire [POINTS-1:0] next_points = (next_state == omf_pkg::OMF_SAFE) ? safePoints : userPoints;

    wire [2:0] irqEvt = {applyCfg, leaveSafe, enterSafe};

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state      <= omf_pkg::OMF_RUN;
            watchCount <= 16'h0000;
            delayCount <= 8'h00;
            heldPoints <= '0;
            points     <= '0;
            inSafe     <= 1'b0;
        end else begin
            state      <= next_state;
            watchCount <= hostSeen ? 16'h0000 : (linkLost ? watchCount : watchCount + 16'h0001);
            if (state != omf_pkg::OMF_WAIT || hostSeen)
                delayCount <= 8'h00;
            else if (tick && !delayDone)
                delayCount <= delayCount + 8'h01;
            if (state == omf_pkg::OMF_RUN)
                heldPoints <= points;
            points     <= next_points;
            inSafe     <= (next_state == omf_pkg::OMF_SAFE);
        end
    end

    // Register storage
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            userPoints   <= `OMF_RST_POINTS;
            stageKind    <= `OMF_RST_KIND;
            stagePattern <= `OMF_RST_PATTERN;
            stageDelay   <= `OMF_RST_DELAY;
            liveKind     <= `OMF_RST_KIND;
            livePattern  <= `OMF_RST_PATTERN;
            liveDelay    <= `OMF_RST_DELAY;
            commitFlag   <= 1'b0;
            watchLimit   <= `OMF_RST_WATCH;
            irqStat      <= 3'h0;
            irqMask      <= 3'h0;
            irq          <= 1'b0;
        end else begin
            if (wrPts)  userPoints   <= wData[POINTS-1:0];
            if (wrKind) stageKind    <= wData[7:0];
            if (wrPat)  stagePattern <= wData[POINTS-1:0];
            if (wrDly)  stageDelay   <= wData[7:0];
            if (wrMsk)  irqMask      <= wData[2:0];
            if (wrWatch) watchLimit  <= {wStrb[1] ? wData[15:8] : watchLimit[15:8],
                                         lane0 ? wData[7:0] : watchLimit[7:0]};
            if (applyCfg) begin
                liveKind    <= stageKind;
                livePattern <= stagePattern;
                liveDelay   <= stageDelay;
            end
            commitFlag <= commitSet;
            irqStat    <= irqEvt | (irqStat & ~(wrIst ? wData[2:0] : 3'h0));
            irq        <= |(irqStat & irqMask);
        end
    end

    // AXI write path
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            awHeld <= 1'b0;
            wHeld  <= 1'b0;
            awAddr <= 8'h00;
            wData  <= 32'h00000000;
            wStrb  <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else begin
            s_axi_awready <= ~awHeld & ~awTake;
            s_axi_wready  <= ~wHeld & ~wTake;
            if (awTake) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (wTake) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrKnown ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                awHeld <= 1'b0;
                wHeld  <= 1'b0;
            end
        end
    end

    // AXI read path; staged config reads back, though write-only to the host link
    wire arTake = s_axi_arvalid & s_axi_arready;
    logic [31:0] rdMux;
    logic        rdOk;
    always_comb begin
        rdOk  = 1'b1;
        rdMux = 32'h00000000;
        case (s_axi_araddr)
            `OMF_OFS_POINTS:  rdMux = 32'(points);
            `OMF_OFS_KIND:    rdMux = 32'(stageKind);
            `OMF_OFS_PATTERN: rdMux = 32'(stagePattern);
            `OMF_OFS_DELAY:   rdMux = 32'(stageDelay);
            `OMF_OFS_COMMIT:  rdMux = 32'(commitFlag);
            `OMF_OFS_STATUS:  rdMux = 32'({linkLost, inSafe});
            `OMF_OFS_IRQSTAT: rdMux = 32'(irqStat);
            `OMF_OFS_IRQMASK: rdMux = 32'(irqMask);
            `OMF_OFS_WATCH:   rdMux = 32'(watchLimit);
            default:          rdOk  = 1'b0;
        endcase
    end
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~arTake;
            if (arTake) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rdMux;
                s_axi_rresp  <= rdOk ? 2'h0 : 2'h2;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Checks
    a_commit_clears: assert property (@(posedge clock) disable iff (reset)
        commitFlag |=> !commitFlag || $past(commitSet)) else $error("commit flag stuck");
    a_commit_applies: assert property (@(posedge clock) disable iff (reset)
        commitFlag |=> liveKind == $past(stageKind) && liveDelay == $past(stageDelay)
                       && livePattern == $past(stagePattern))
        else $error("commit not applied");
    a_no_commit_hold: assert property (@(posedge clock) disable iff (reset)
        !commitFlag |=> $stable(liveKind) && $stable(livePattern)) else $error("config changed without commit");
    a_pattern_out: assert property (@(posedge clock) disable iff (reset)
        (next_state == omf_pkg::OMF_SAFE && kindPat) |=> points == $past(livePattern))
        else $error("pattern not driven");
    a_off_out: assert property (@(posedge clock) disable iff (reset)
        (next_state == omf_pkg::OMF_SAFE && kindOff) |=> points == '0) else $error("off not driven");
    a_zero_delay: assert property (@(posedge clock) disable iff (reset)
        (state == omf_pkg::OMF_WAIT && liveDelay == 8'h00 && !hostSeen) |=> state == omf_pkg::OMF_SAFE)
        else $error("zero delay not immediate");
    a_alive_restart: assert property (@(posedge clock) disable iff (reset)
        (state == omf_pkg::OMF_WAIT && hostSeen) |=> delayCount == 8'h00 && state == omf_pkg::OMF_RUN)
        else $error("delay not restarted");
    a_safe_needs_loss: assert property (@(posedge clock) disable iff (reset)
        $rose(inSafe) |-> $past(state) == omf_pkg::OMF_WAIT) else $error("safe without loss");
    a_run_points: assert property (@(posedge clock) disable iff (reset)
        (next_state == omf_pkg::OMF_RUN) |=> points == $past(userPoints)) else $error("points mismatch");
    a_delay_bound: assert property (@(posedge clock) disable iff (reset)
        delayCount <= liveDelay || state != omf_pkg::OMF_WAIT) else $error("delay overrun");

    c_enter_safe:  cover property (@(posedge clock) disable iff (reset) enterSafe);
    c_leave_safe:  cover property (@(posedge clock) disable iff (reset) leaveSafe);
    c_commit:      cover property (@(posedge clock) disable iff (reset) commitFlag);
    c_pattern_use: cover property (@(posedge clock) disable iff (reset) inSafe && kindPat);
endmodule : omf_output_failsafe

// >>> bench/omf_host_model.sv
`timescale 1ns/1ns

// Remote host: while talking it shows link traffic every PERIOD cycles
module omf_host_model #(
    parameter int PERIOD = 4
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // Control
    input  wire logic talk,
    // Link activity
    output logic      hostAlive
);
    logic [7:0] count;

    // Traffic on the first cycle of talking, so a one-cycle burst still shows
    assign hostAlive = talk && (count == 8'h00);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            count <= 8'h00;
        end else if (!talk || count == 8'(PERIOD - 1)) begin
            count <= 8'h00;
        end else begin
            count <= count + 8'h01;
        end
    end
endmodule : omf_host_model

// >>> bench/omf_output_failsafe_tb.sv
`timescale 1ns/1ns
`include "omf_cfg.svh"

module omf_output_failsafe_tb;
    localparam int TICK  = 10;
    localparam int WATCH = 20;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        talk = 1'b0;
    logic        hostAlive;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, points;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        inSafe, irq, irqA;
    int          errors = 0;
    int          cmpCount = 0;
    int          n;
    int          dly[3] = '{0, 3, 255};

    always #5 clock = ~clock;

    omf_host_model host_u (.clock(clock), .reset(reset), .talk(talk), .hostAlive(hostAlive));

    omf_output_failsafe #(.POINTS(8), .TICK_CYCLES(TICK)) dut_u (
        .clock(clock), .reset(reset), .hostAlive(hostAlive),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rready(s_axi_rready), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .points(points), .inSafe(inSafe), .irq(irq)
    );

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmpCount, errors);
        if (errors == 0 && cmpCount > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            errors++;
        end
    endtask : chk

    task automatic stall();
        $display("BAD t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
        errors++;
        conclude();
    endtask : stall

    // Entered just after a rising edge; every wait is bounded
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
        logic awOpen, wOpen, bOpen;
        int   k;
        awOpen = 1'b1;
        wOpen = 1'b1;
        bOpen = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 200 && bOpen; k++) begin
            @(posedge clock);
            if (!awOpen && !wOpen && s_axi_bvalid === 1'b1) begin
                chk(s_axi_bresp, er);
                bOpen = 1'b0;
            end
            if (awOpen && s_axi_awready === 1'b1) begin
                s_axi_awvalid <= 1'b0;
                awOpen = 1'b0;
            end
            if (wOpen && s_axi_wready === 1'b1) begin
                s_axi_wvalid <= 1'b0;
                wOpen = 1'b0;
            end
        end
        if (bOpen) stall();
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = 2'b00);
        logic arOpen, rOpen;
        int   k;
        arOpen = 1'b1;
        rOpen = 1'b1;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 200 && rOpen; k++) begin
            @(posedge clock);
            if (arOpen && s_axi_arready === 1'b1) begin
                s_axi_arvalid <= 1'b0;
                arOpen = 1'b0;
            end else if (!arOpen && s_axi_rvalid === 1'b1) begin
                chk(s_axi_rdata, ed);
                chk(s_axi_rresp, er);
                rOpen = 1'b0;
            end
        end
        if (rOpen) stall();
    endtask : rd

    task automatic waitSafe(input logic t, output int cnt);
        for (cnt = 0; cnt < 4000 && inSafe !== t; cnt++) @(posedge clock);
        if (inSafe !== t) stall();
    endtask : waitSafe

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 48'h0;
        s_axi_wstrb <= 4'hF;
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        talk <= 1'b1;
        repeat (2) @(posedge clock);
        rd(`OMF_OFS_POINTS, `OMF_RST_POINTS);
        rd(`OMF_OFS_KIND, `OMF_RST_KIND);
        rd(`OMF_OFS_PATTERN, `OMF_RST_PATTERN);
        rd(`OMF_OFS_DELAY, `OMF_RST_DELAY);
        rd(`OMF_OFS_WATCH, `OMF_RST_WATCH);
        wr(`OMF_OFS_WATCH, WATCH);
        wr(`OMF_OFS_POINTS, 32'h0000_00FF);
        @(posedge clock);
        chk(points, 32'h0000_00FF);
        rd(`OMF_OFS_POINTS, 32'h0000_00FF);
        // Lane zero off: accepted, but the byte is left alone
        s_axi_wstrb <= 4'hE;
        wr(`OMF_OFS_POINTS, 32'h0000_0000);
        s_axi_wstrb <= 4'hF;
        rd(`OMF_OFS_POINTS, 32'h0000_00FF);
        wr(8'h24, 32'h0, 2'b10);
        rd(8'h24, 32'h0, 2'b10);
        $display("registers test done");
        for (int k = 1; k <= 3; k++) begin
            wr(`OMF_OFS_POINTS, 32'h0000_005A);
            wr(`OMF_OFS_PATTERN, 32'h0000_00C3);
            wr(`OMF_OFS_DELAY, 32'h0);
            wr(`OMF_OFS_KIND, k);
            wr(`OMF_OFS_COMMIT, 32'h1);
            rd(`OMF_OFS_COMMIT, 32'h0);
            talk <= 1'b0;
            waitSafe(1'b1, n);
            chk(points, k == 1 ? 32'h00 : (k == 2 ? 32'hC3 : 32'h5A));
            talk <= 1'b1;
            waitSafe(1'b0, n);
            chk(points, 32'h5A);
        end
        $display("safe kinds test done");
        wr(`OMF_OFS_KIND, 32'h2);
        wr(`OMF_OFS_PATTERN, 32'hFF);
        wr(`OMF_OFS_COMMIT, 32'h0);
        talk <= 1'b0;
        waitSafe(1'b1, n);
        chk(points, 32'h5A);
        talk <= 1'b1;
        waitSafe(1'b0, n);
        $display("staging test done");
        foreach (dly[i]) begin
            wr(`OMF_OFS_DELAY, dly[i]);
            wr(`OMF_OFS_KIND, 32'h1);
            wr(`OMF_OFS_COMMIT, 32'h1);
            talk <= 1'b0;
            waitSafe(1'b1, n);
            chk(n >= WATCH + dly[i] * TICK - 8 && n <= WATCH + dly[i] * TICK + 8, 1);
            talk <= 1'b1;
            waitSafe(1'b0, n);
        end
        wr(`OMF_OFS_DELAY, 32'h3);
        wr(`OMF_OFS_COMMIT, 32'h1);
        talk <= 1'b0;
        repeat (WATCH + 15) @(posedge clock);
        chk(inSafe, 0);
        talk <= 1'b1;
        @(posedge clock);
        talk <= 1'b0;
        waitSafe(1'b1, n);
        chk(n >= WATCH + 3 * TICK - 2, 1);
        talk <= 1'b1;
        waitSafe(1'b0, n);
        $display("delay test done");
        // A set mask bit lets its status bit through to irq
        rd(`OMF_OFS_IRQSTAT, 32'h7);
        wr(`OMF_OFS_IRQMASK, 32'h0);
        repeat (2) @(posedge clock);
        irqA = irq;
        wr(`OMF_OFS_IRQMASK, 32'h7);
        repeat (2) @(posedge clock);
        chk(irqA, 0);
        chk(irq, 1);
        wr(`OMF_OFS_IRQSTAT, 32'h7);
        repeat (2) @(posedge clock);
        chk(irq, 0);
        rd(`OMF_OFS_IRQSTAT, 32'h0);
        $display("interrupt test done");
        conclude();
    end
endmodule : omf_output_failsafe_tb
